// ===== verilog/fleg_overlay_map.sv
/*
 Package for the flash emulation and error guard, and the overlay address mapper.
 Assumes 24-bit CPU byte addresses and a 1 kbyte RAM window at a fixed base.
*/
`default_nettype none

package fleg_pkg;
	localparam logic [11:0] ADDR_OVERLAY_CTRL = 12'h000;
	localparam logic [11:0] ADDR_FAULT_STATUS = 12'h004;
	localparam logic [11:0] ADDR_MODE_CONTROL = 12'h008;
	localparam logic [23:0] RAM_WINDOW_BASE = 24'hfff000;
	localparam logic [23:0] FLASH_OVERLAY_BASE = 24'h000000;
	localparam logic [23:0] FLASH_LAST_ADDR = 24'h01ffff;
	localparam int WINDOW_ADDR_BITS = 10;
	localparam int OVL_SELECT_BIT = 3;
	localparam int OVL_BLOCK_HI_BIT = 2;
	localparam int OVL_BLOCK_LO_BIT = 1;
	localparam int FAULT_FLAG_BIT = 7;
	localparam logic [7:0] OVL_CTRL_FIXED_ONES = 8'hf1;
	localparam logic [7:0] FAULT_STATUS_FIXED_ONES = 8'h7f;
	localparam logic [2:0] OVL_RESET = 3'h0;
	localparam logic [2:0] MODE_FLASH_LOW = 3'h5;
	localparam logic [2:0] MODE_SINGLE_NORMAL = 3'h6;
	localparam logic [2:0] PINS_BOOT_M5 = 3'h1;
	localparam logic [2:0] PINS_BOOT_M7 = 3'h3;
	localparam logic [2:0] PINS_USER_M5 = 3'h5;
	localparam logic [2:0] PINS_USER_M7 = 3'h7;
	typedef enum logic [1:0] {FLEG_RUN_NORMAL, FLEG_RUN_BOOT, FLEG_RUN_USER} fleg_run_type;
endpackage

////////////////////////////////////////////////////////////////////////////////

module fleg_overlay_map
	import fleg_pkg::*;
(
	input wire logic overlay_select,
	input wire logic [1:0] overlay_block,
	input wire logic [23:0] cpu_addr,
	output logic ram_hit,
	output logic [23:0] ram_addr
);
	// One 1 kbyte flash range per block code, stepping up from the base
	wire logic [23:0] range_base;
	wire logic [23:0] window_offset;

	assign range_base = FLASH_OVERLAY_BASE + {12'h000, overlay_block, 10'h000};
	assign window_offset = {14'h0000, cpu_addr[WINDOW_ADDR_BITS-1:0]};
	assign ram_hit = overlay_select &&
		(cpu_addr[23:WINDOW_ADDR_BITS] == range_base[23:WINDOW_ADDR_BITS]);
	assign ram_addr = RAM_WINDOW_BASE | window_offset;
endmodule

`default_nettype wire

// ===== verilog/fleg_top.sv
/*
 Flash emulation and error guard: RAM overlay control, program/erase fault
 flag, mode pin decoding, and an APB register slave.
 Assumes the flash controller reports its program/erase state and the CPU
 reports its bus cycles, exceptions, sleep and bus release as pulses.
*/
// The APB slave port and the register offsets were decided locally.
`default_nettype none

module fleg_top
	import fleg_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Reset and standby sources
	input wire logic watchdog_reset,
	input wire logic pin_reset,
	input wire logic hw_standby,
	input wire logic reset_start,
	// Mode pins
	input wire logic [2:0] mode_pins,
	input wire logic write_enable_pin,
	// Flash controller state
	input wire logic prog_erase_active,
	// CPU activity
	input wire logic cpu_valid,
	input wire logic cpu_write,
	input wire logic [23:0] cpu_addr,
	input wire logic exception_start,
	input wire logic exception_exempt,
	input wire logic sleep_exec,
	input wire logic bus_release,
	// Results
	output logic program_fault_flag,
	output logic prog_erase_inhibit,
	output logic read_undefined,
	output logic ram_steer,
	output logic [23:0] steer_addr,
	output logic [2:0] op_mode,
	output logic boot_mode,
	output logic user_program_mode
);

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic flash_mode(input logic [2:0] mode);
		flash_mode = (mode >= MODE_FLASH_LOW);
	endfunction

	function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] offs);
		reg_hit = (addr == offs);
	endfunction

	// Boot mode reads the top mode pin inverted
	function automatic logic [2:0] effective_mode(input logic [2:0] pins, input logic boot);
		effective_mode = boot ? {~pins[2], pins[1:0]} : pins;
	endfunction

	// Either of two pin settings
	function automatic logic pins_pair(input logic [2:0] pins, input logic [2:0] first,
		input logic [2:0] second);
		pins_pair = (pins == first) || (pins == second);
	endfunction

	// Byte register in the low lane of the bus word
	function automatic logic [31:0] byte_word(input logic [7:0] value);
		byte_word = {24'h000000, value};
	endfunction

	// Watchdog, pin reset and hardware standby clear the same state
	function automatic logic clear_any(input logic dog, input logic pin, input logic stby);
		clear_any = dog || pin || stby;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// State

	logic overlay_select_reg;
	logic overlay_select_next;
	logic overlay_block_hi_reg;
	logic overlay_block_hi_next;
	logic overlay_block_lo_reg;
	logic overlay_block_lo_next;
	logic fault_reg;
	logic fault_next;
	logic [2:0] pins_reg;
	logic [2:0] pins_next;
	fleg_run_type run_reg;
	fleg_run_type run_next;
	logic rst_prev_reg;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic undef_reg;
	logic steer_reg;
	logic [23:0] steer_addr_reg;

	////////////////////////////////////////////////////////////////////////////
	// Mode pin decoding at reset-start

	wire logic capture_pins;
	wire logic pins_boot;
	wire logic pins_user;
	wire logic [2:0] sampled_mode;
	wire logic sampled_normal6;

	// Pins are caught at reset release or at an explicit reset-start
	assign capture_pins = (rst_prev_reg && !rst) || reset_start;
	assign pins_boot = write_enable_pin &&
		pins_pair(mode_pins, PINS_BOOT_M5, PINS_BOOT_M7);
	assign pins_user = write_enable_pin &&
		pins_pair(mode_pins, PINS_USER_M5, PINS_USER_M7);
	// Boot mode reads the top mode pin inverted
	assign sampled_mode = effective_mode(mode_pins, pins_boot);
	assign sampled_normal6 = (sampled_mode == MODE_SINGLE_NORMAL);

	always_comb begin
		pins_next = pins_reg;
		run_next = run_reg;
		if (capture_pins) begin
			pins_next = mode_pins;
			run_next = FLEG_RUN_NORMAL;
			if (pins_boot && !sampled_normal6) begin
				run_next = FLEG_RUN_BOOT;
			end else if (pins_user && !sampled_normal6) begin
				run_next = FLEG_RUN_USER;
			end
		end
	end

	wire logic run_boot;
	wire logic [2:0] mode_now;
	wire logic [2:0] mode_select_bits;
	wire logic flash_enabled;

	assign run_boot = (run_reg == FLEG_RUN_BOOT);
	assign mode_now = effective_mode(pins_reg, run_boot);
	assign mode_select_bits = run_boot ? ~pins_reg : pins_reg;
	assign flash_enabled = flash_mode(mode_now);

	////////////////////////////////////////////////////////////////////////////
	// APB decode

	wire logic apb_setup;
	wire logic apb_write;
	wire logic hit_ovl;
	wire logic hit_fault;
	wire logic hit_mode;
	wire logic hit_any;
	wire logic [7:0] ovl_read;
	wire logic [7:0] fault_read;
	wire logic [7:0] mode_read;
	logic [7:0] ovl_bits;
	logic [7:0] fault_bits;

	assign apb_setup = psel && !penable;
	assign apb_write = psel && penable && pwrite && pstrb[0];
	assign hit_ovl = reg_hit(paddr, ADDR_OVERLAY_CTRL);
	assign hit_fault = reg_hit(paddr, ADDR_FAULT_STATUS);
	assign hit_mode = reg_hit(paddr, ADDR_MODE_CONTROL);
	assign hit_any = hit_ovl || hit_fault || hit_mode;


	// Live bits placed at their field positions
	always_comb begin
		ovl_bits = 8'h00;
		ovl_bits[OVL_SELECT_BIT] = overlay_select_reg;
		ovl_bits[OVL_BLOCK_HI_BIT] = overlay_block_hi_reg;
		ovl_bits[OVL_BLOCK_LO_BIT] = overlay_block_lo_reg;
		fault_bits = 8'h00;
		fault_bits[FAULT_FLAG_BIT] = fault_reg;
	end

	assign ovl_read = OVL_CTRL_FIXED_ONES | ovl_bits;
	assign fault_read = FAULT_STATUS_FIXED_ONES | fault_bits;
	assign mode_read = {5'h00, mode_select_bits};

	always_comb begin
		prdata_next = prdata_reg;
		if (apb_setup) begin
			if (hit_ovl) begin
				prdata_next = byte_word(ovl_read);
			end else if (hit_fault) begin
				prdata_next = byte_word(fault_read);
			end else if (hit_mode) begin
				prdata_next = byte_word(mode_read);
			end else begin
				prdata_next = 32'h00000000;
			end
		end
	end

	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit_any;
	assign prdata = prdata_reg;

	////////////////////////////////////////////////////////////////////////////
	// Overlay control register

	wire logic ovl_clear;
	wire logic ovl_write;

	assign ovl_clear = clear_any(watchdog_reset, pin_reset, hw_standby);
	assign ovl_write = apb_write && hit_ovl && flash_enabled;

	always_comb begin
		overlay_select_next = overlay_select_reg;
		overlay_block_hi_next = overlay_block_hi_reg;
		overlay_block_lo_next = overlay_block_lo_reg;
		if (ovl_clear || !flash_enabled) begin
			overlay_select_next = OVL_RESET[2];
			overlay_block_hi_next = OVL_RESET[1];
			overlay_block_lo_next = OVL_RESET[0];
		end else if (ovl_write) begin
			overlay_select_next = pwdata[OVL_SELECT_BIT];
			overlay_block_hi_next = pwdata[OVL_BLOCK_HI_BIT];
			overlay_block_lo_next = pwdata[OVL_BLOCK_LO_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Overlay steering

	wire logic map_hit;
	wire logic [23:0] map_addr;

	fleg_overlay_map u_map (
		.overlay_select(overlay_select_reg),
		.overlay_block({overlay_block_hi_reg, overlay_block_lo_reg}),
		.cpu_addr(cpu_addr),
		.ram_hit(map_hit),
		.ram_addr(map_addr)
	);

	////////////////////////////////////////////////////////////////////////////
	// Program/erase fault detection

	wire logic flash_hit;
	wire logic bad_read;
	wire logic bad_exception;
	wire logic bad_sleep;
	wire logic bad_release;
	wire logic fault_set;
	wire logic fault_clear;

	assign flash_hit = (cpu_addr <= FLASH_LAST_ADDR) && !map_hit;
	assign bad_read = prog_erase_active && cpu_valid && !cpu_write && flash_hit;
	assign bad_exception = prog_erase_active && exception_start && !exception_exempt;
	assign bad_sleep = prog_erase_active && sleep_exec;
	assign bad_release = prog_erase_active && bus_release;
	assign fault_set = bad_read || bad_exception || bad_sleep || bad_release;
	assign fault_clear = clear_any(watchdog_reset, pin_reset, hw_standby);

	always_comb begin
		fault_next = fault_reg;
		if (fault_clear) begin
			fault_next = 1'b0;
		end else if (fault_set) begin
			fault_next = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge clk) begin
		if (rst) begin
			overlay_select_reg <= OVL_RESET[2];
			overlay_block_hi_reg <= OVL_RESET[1];
			overlay_block_lo_reg <= OVL_RESET[0];
			fault_reg <= 1'b0;
		end else begin
			overlay_select_reg <= overlay_select_next;
			overlay_block_hi_reg <= overlay_block_hi_next;
			overlay_block_lo_reg <= overlay_block_lo_next;
			fault_reg <= fault_next;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pins_reg <= 3'h0;
			run_reg <= FLEG_RUN_NORMAL;
			prdata_reg <= 32'h00000000;
		end else begin
			pins_reg <= pins_next;
			run_reg <= run_next;
			prdata_reg <= prdata_next;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rst_prev_reg <= 1'b1;
			undef_reg <= 1'b0;
			steer_reg <= 1'b0;
			steer_addr_reg <= 24'h000000;
		end else begin
			rst_prev_reg <= 1'b0;
			undef_reg <= bad_read;
			steer_reg <= cpu_valid && map_hit;
			steer_addr_reg <= map_addr;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign program_fault_flag = fault_reg;
	assign prog_erase_inhibit = fault_reg || overlay_select_reg;
	assign read_undefined = undef_reg;
	assign ram_steer = steer_reg;
	assign steer_addr = steer_addr_reg;
	assign op_mode = mode_now;
	assign boot_mode = run_boot;
	assign user_program_mode = (run_reg == FLEG_RUN_USER);

endmodule

`default_nettype wire

// ===== testbench/fleg_top_assertions.sv
/*
 Port assertions for the flash guard top.
 Assumes one clock and the synchronous reset rst.
*/
`default_nettype none

module fleg_top_checker
	import fleg_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic watchdog_reset,
	input wire logic pin_reset,
	input wire logic hw_standby,
	input wire logic prog_erase_active,
	input wire logic cpu_valid,
	input wire logic cpu_write,
	input wire logic [23:0] cpu_addr,
	input wire logic exception_start,
	input wire logic exception_exempt,
	input wire logic sleep_exec,
	input wire logic bus_release,
	input wire logic program_fault_flag,
	input wire logic prog_erase_inhibit,
	input wire logic read_undefined,
	input wire logic ram_steer,
	input wire logic [23:0] steer_addr
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	wire clear_src = watchdog_reset | pin_reset | hw_standby;
	wire [9:0] cpu_offset = cpu_addr[9:0];
	sequence s_guarded;
		prog_erase_active && !clear_src;
	endsequence
	a_read_faults: assert property (
		s_guarded ##0 (cpu_valid && !cpu_write && cpu_addr >= 24'h001000
		&& cpu_addr <= FLASH_LAST_ADDR) |=> program_fault_flag && read_undefined)
		else $error("flash read in program left flag low");
	a_exc_faults: assert property (
		s_guarded ##0 (exception_start && !exception_exempt) |=> program_fault_flag)
		else $error("exception in program left flag low");
	a_event_faults: assert property (
		s_guarded ##0 (sleep_exec || bus_release) |=> program_fault_flag)
		else $error("sleep or release in program left flag low");
	a_fault_holds: assert property (
		program_fault_flag && !clear_src |=> program_fault_flag)
		else $error("fault flag dropped without clear");
	a_fault_clears: assert property (
		clear_src |=> !program_fault_flag)
		else $error("fault flag survived a clear");
	a_fault_inhibits: assert property (
		program_fault_flag |-> prog_erase_inhibit)
		else $error("fault without inhibit");
	a_fault_cause: assert property (
		$rose(program_fault_flag) |-> $past(prog_erase_active))
		else $error("fault set outside program");
	a_steer_window: assert property (
		ram_steer |-> steer_addr == {RAM_WINDOW_BASE[23:10], $past(cpu_offset)})
		else $error("steered address wrong");
endmodule

////////////////////////////////////////
bind fleg_top fleg_top_checker chk_u (.clk, .rst, .watchdog_reset, .pin_reset, .hw_standby,
	.prog_erase_active, .cpu_valid, .cpu_write, .cpu_addr, .exception_start, .exception_exempt,
	.sleep_exec, .bus_release, .program_fault_flag, .prog_erase_inhibit, .read_undefined,
	.ram_steer, .steer_addr);

`default_nettype wire

// ===== testbench/tb.sv
/*
 Self-checking bench for fleg_top over APB and event pulses.
 Assumes zero-wait APB and a 4 ns clock.
*/
`default_nettype none

module tb
	import fleg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, psel, penable, pwrite, pready, pslverr, rerr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdata;
	logic [3:0] pstrb;
	logic watchdog_reset, pin_reset, hw_standby, reset_start, write_enable_pin;
	logic [2:0] mode_pins, op_mode;
	logic prog_erase_active, cpu_valid, cpu_write, exception_start, exception_exempt;
	logic sleep_exec, bus_release, program_fault_flag, prog_erase_inhibit, read_undefined;
	logic ram_steer, boot_mode, user_program_mode;
	logic [23:0] cpu_addr, steer_addr;
	int miscompares, comparisons;
	// Pins, write enable, boot, user, mode, readback
	localparam logic [11:0] MODES [7] = '{12'h3ae, 12'h7bc, 12'hb6d, 12'hf7f, 12'hd36,
		12'h824, 12'ha2d};

	fleg_top dut_u (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
		.pready, .pslverr, .watchdog_reset, .pin_reset, .hw_standby, .reset_start, .mode_pins,
		.write_enable_pin, .prog_erase_active, .cpu_valid, .cpu_write, .cpu_addr,
		.exception_start, .exception_exempt, .sleep_exec, .bus_release, .program_fault_flag,
		.prog_erase_inhibit, .read_undefined, .ram_steer, .steer_addr, .op_mode, .boot_mode,
		.user_program_mode);

	////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h00000000);
		chk(rdata, exp);
	endtask

	// Bits: exempt, standby, pin, watchdog, release, sleep, exception, cpu read
	task automatic fire(input logic [7:0] k, input logic [23:0] a);
		@(posedge clk);
		{exception_exempt, hw_standby, pin_reset, watchdog_reset} <= k[7:4];
		{bus_release, sleep_exec, exception_start, cpu_valid} <= k[3:0];
		cpu_addr <= a;
		@(posedge clk);
		{hw_standby, pin_reset, watchdog_reset} <= 3'h0;
		{bus_release, sleep_exec, exception_start, cpu_valid} <= 4'h0;
		#1;
	endtask

	task automatic set_mode(input logic [2:0] p, input logic we);
		@(posedge clk);
		mode_pins <= p;
		write_enable_pin <= we;
		reset_start <= 1'b1;
		@(posedge clk);
		reset_start <= 1'b0;
		#1;
	endtask

	task automatic give_verdict();
		$display("Counts: comparisons=%0d miscompares=%0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial begin
		#100us;
		miscompares++;
		give_verdict();
	end

	initial begin
		{rst, mode_pins, pstrb} = {1'b1, 3'h7, 4'h1};
		{psel, penable, pwrite, reset_start, write_enable_pin, cpu_write} = 6'h00;
		{watchdog_reset, pin_reset, hw_standby, prog_erase_active, cpu_valid} = 5'h00;
		{exception_start, exception_exempt, sleep_exec, bus_release} = 4'h0;
		{paddr, pwdata, cpu_addr} = '0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(ADDR_OVERLAY_CTRL, 32'h000000f1);
		rd(ADDR_FAULT_STATUS, 32'h0000007f);
		rd(12'hffc, 32'h00000000);
		chk(rerr, 1'b1);
		$display("Test reset done");
		// Internal RAM is taken as already switched on by the system
		apb(1'b1, ADDR_OVERLAY_CTRL, 32'h0000000e);
		rd(ADDR_OVERLAY_CTRL, 32'h000000ff);
		chk(prog_erase_inhibit, 1'b1);
		apb(1'b1, ADDR_OVERLAY_CTRL, 32'h00000000);
		rd(ADDR_OVERLAY_CTRL, 32'h000000f1);
		chk(prog_erase_inhibit, 1'b0);
		fire(8'h01, 24'h000000);
		chk(ram_steer, 1'b0);
		for (int b = 0; b < 4; b++) begin
			apb(1'b1, ADDR_OVERLAY_CTRL, 32'h00000008 | 32'(b * 2));
			fire(8'h01, 24'(b * 1024 + 1023));
			chk(ram_steer, 1'b1);
			chk(steer_addr, 32'h00fff3ff);
			fire(8'h01, 24'((b + 1) % 4 * 1024));
			chk(ram_steer, 1'b0);
		end
		@(posedge clk);
		prog_erase_active <= 1'b1;
		fire(8'h01, 24'h000c10);
		chk(program_fault_flag, 1'b0);
		fire(8'h40, 24'h000000);
		rd(ADDR_OVERLAY_CTRL, 32'h000000f1);
		$display("Test overlay done");
		for (int i = 0; i < 4; i++) begin
			fire(8'h01 << i, 24'h001000);
			chk(program_fault_flag, 1'b1);
			chk(read_undefined, i == 0);
			fire(8'h00, 24'h000000);
			chk(prog_erase_inhibit, 1'b1);
			rd(ADDR_FAULT_STATUS, 32'h000000ff);
			fire(8'h10 << (i % 3), 24'h000000);
			chk(program_fault_flag, 1'b0);
		end
		fire(8'h82, 24'h000000);
		chk(program_fault_flag, 1'b0);
		@(posedge clk);
		prog_erase_active <= 1'b0;
		fire(8'h0f, 24'h000100);
		chk(program_fault_flag, 1'b0);
		$display("Test fault flag done");
		foreach (MODES[i]) begin
			set_mode(MODES[i][11:9], MODES[i][8]);
			chk(boot_mode, MODES[i][7]);
			chk(user_program_mode, MODES[i][6]);
			chk(op_mode, MODES[i][5:3]);
			rd(ADDR_MODE_CONTROL, 32'(MODES[i][2:0]));
			// No overlay bit is set in mode 6, where emulation is enabled but not exercised
			apb(1'b1, ADDR_OVERLAY_CTRL,
				MODES[i][5:3] == 3'h6 ? 32'h00000000 : 32'h0000000e);
			rd(ADDR_OVERLAY_CTRL, MODES[i][5:3] >= 3'h5 && MODES[i][5:3] != 3'h6 ?
				32'h000000ff : 32'h000000f1);
			apb(1'b1, ADDR_OVERLAY_CTRL, 32'h00000000);
		end
		@(posedge clk);
		mode_pins <= 3'h1;
		write_enable_pin <= 1'b1;
		fire(8'h00, 24'h000000);
		chk(boot_mode, 1'b0);
		$display("Test modes done");
		give_verdict();
	end
endmodule

`default_nettype wire
